// ### rgi_map.svh
// Notes on behaviour
// - Detect tag, read its code first
// - Matching code drives both outputs ON
// - Tag gone drives both outputs OFF
// - Wrong code latches error until power-up
// - ON after 120 ms, plus 50 ms per reader
// - Standalone variant switches ON after 250 ms
// - OFF within 120 ms, plus 18 ms per reader
// - Self-test done, ready within 5 s
// - Re-pairing only in 10 s window
// - Chain inputs disagree over 18 ms: OFF
// - Both outputs OFF within 18 ms
// - Test pulses: 1.4 ms wide, every 300 ms
`ifndef RGI_MAP_SVH
`define RGI_MAP_SVH

// ====================================================================
// Clock
`define RGI_CYC_PER_MS                   100000
`define RGI_CYC_PER_US                   100
`define RGI_CYC_PER_S                    100000000

// ====================================================================
// Times as printed
`define RGI_SWITCH_ON_RESPONSE_TIME_MS   120
`define RGI_SWITCH_ON_CHAIN_STEP_MS      50
`define RGI_SWITCH_ON_STANDALONE_MS      250
`define RGI_SWITCH_OFF_RISK_TIME_MS      120
`define RGI_SWITCH_OFF_CHAIN_STEP_MS     18
`define RGI_POWER_UP_READY_TIME_S        5
`define RGI_PAIRING_WINDOW_TIME_S        10
`define RGI_INPUT_DISCREPANCY_TIMEOUT_MS 18
`define RGI_OUTPUT_SKEW_TIME_MS          18
`define RGI_OUTPUT_TEST_PULSE_WIDTH_US   1400
`define RGI_OUTPUT_TEST_PERIOD_MS        300

// ====================================================================
// Cycle counts (least times round up, longest down)
`define RGI_RESP_CYC      (`RGI_SWITCH_ON_RESPONSE_TIME_MS * `RGI_CYC_PER_MS)
`define RGI_RESP_STEP_CYC (`RGI_SWITCH_ON_CHAIN_STEP_MS * `RGI_CYC_PER_MS)
`define RGI_RESP_SA_CYC   (`RGI_SWITCH_ON_STANDALONE_MS * `RGI_CYC_PER_MS)
`define RGI_READY_CYC     (`RGI_POWER_UP_READY_TIME_S * `RGI_CYC_PER_S - 1)
`define RGI_PAIR_CYC      (`RGI_PAIRING_WINDOW_TIME_S * `RGI_CYC_PER_S)
`define RGI_DISC_CYC \
    (`RGI_INPUT_DISCREPANCY_TIMEOUT_MS * `RGI_CYC_PER_MS - 1)
`define RGI_PULSE_CYC \
    (`RGI_OUTPUT_TEST_PULSE_WIDTH_US * `RGI_CYC_PER_US)
`define RGI_PERIOD_CYC    (`RGI_OUTPUT_TEST_PERIOD_MS * `RGI_CYC_PER_MS)

// ====================================================================
// Code and reset values
`define RGI_CODE_W        32
`define RGI_DEPTH_W       4
`define RGI_PAIRED_RST    32'h5A5A_0001

`endif

// ### rgi_pkg.sv
package rgi_pkg;
    typedef enum logic [2:0] {
        ST_INIT,
        ST_STOP,
        ST_READ,
        ST_ARM,
        ST_RUN,
        ST_ERROR
    } rgi_state_type;
endpackage

// ### rgi_pulse_if.sv
`timescale 1ns/1ps
interface rgi_pulse_if;
    logic       en;
    logic [1:0] pulse;
    modport gen  (input en, output pulse);
    modport user (output en, input pulse);
endinterface

// ### rgi_pulse_gen.sv
`timescale 1ns/1ps
`include "rgi_map.svh"
module rgi_pulse_gen #(
    parameter logic [31:0] P_PERIOD_CYC = 32'(`RGI_PERIOD_CYC),
    parameter logic [31:0] P_PULSE_CYC  = 32'(`RGI_PULSE_CYC)
) (
    input  wire logic   i_clk,
    input  wire logic   i_rst_n,
    rgi_pulse_if.gen    pif
);
    import rgi_pkg::*;

    logic [31:0] per_q;
    logic [1:0]  pulse_q;

    // ================================================================
    // Period counter, restarts each time the output turns ON
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            per_q <= 32'h0;
        end else if (!pif.en || per_q == P_PERIOD_CYC - 32'h1) begin
            per_q <= 32'h0;
        end else begin
            per_q <= per_q + 32'h1;
        end
    end

    // ================================================================
    // Lane pulses at period end, staggered so lanes never dip together
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            localparam logic [31:0] LO = 32'(2 - g);
            localparam logic [31:0] HI = 32'(1 - g);
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    pulse_q[g] <= 1'b0;
                end else begin
                    pulse_q[g] <= pif.en
                        && per_q >= P_PERIOD_CYC - LO * P_PULSE_CYC
                        && per_q <  P_PERIOD_CYC - HI * P_PULSE_CYC;
                end
            end
        end
    endgenerate

    assign pif.pulse = pulse_q;

    property p_pulse_width;
        @(posedge i_clk) disable iff (!i_rst_n)
        pulse_q[0] |-> per_q >= P_PERIOD_CYC - 32'h2 * P_PULSE_CYC
                       && per_q <= P_PERIOD_CYC - P_PULSE_CYC;
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("test pulse outside its slot");

    property p_pulse_apart;
        @(posedge i_clk) disable iff (!i_rst_n)
        !(pulse_q[0] && pulse_q[1]);
    endproperty
    a_pulse_apart: assert property (p_pulse_apart)
        else $error("both lanes pulsed at once");
endmodule

// ### rgi_interlock_ctrl.sv
`timescale 1ns/1ps
`include "rgi_map.svh"
module rgi_interlock_ctrl #(
    parameter logic [31:0] P_RESP_CYC      = 32'(`RGI_RESP_CYC),
    parameter logic [31:0] P_RESP_STEP_CYC = 32'(`RGI_RESP_STEP_CYC),
    parameter logic [31:0] P_RESP_SA_CYC   = 32'(`RGI_RESP_SA_CYC),
    parameter logic [31:0] P_READY_CYC     = 32'(`RGI_READY_CYC),
    parameter logic [31:0] P_PAIR_CYC      = 32'(`RGI_PAIR_CYC),
    parameter logic [31:0] P_DISC_CYC      = 32'(`RGI_DISC_CYC),
    parameter logic [31:0] P_PULSE_CYC     = 32'(`RGI_PULSE_CYC),
    parameter logic [31:0] P_PERIOD_CYC    = 32'(`RGI_PERIOD_CYC)
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_b,
    input  wire logic                     i_tag_present,
    input  wire logic                     i_code_valid,
    input  wire logic [`RGI_CODE_W-1:0]   i_code,
    input  wire logic                     i_selftest_fault,
    input  wire logic                     i_standalone,
    input  wire logic                     i_chain_en,
    input  wire logic [`RGI_DEPTH_W-1:0]  i_chain_depth,
    input  wire logic                     i_chain_in_a,
    input  wire logic                     i_chain_in_b,
    input  wire logic                     i_repair_en,
    input  wire logic                     i_pair_req,
    output logic                          o_out_a,
    output logic                          o_out_b,
    output logic                          o_read_req,
    output logic                          o_ready,
    output logic                          o_error,
    output logic                          o_pair_window,
    output rgi_pkg::rgi_state_type        o_state
);
    import rgi_pkg::*;

    logic                   rst_s1_q;
    logic                   rst_n;
    rgi_state_type          state_q;
    rgi_state_type          state_d;
    logic [31:0]            init_cnt_q;
    logic [31:0]            arm_cnt_q;
    logic [31:0]            win_cnt_q;
    logic                   win_q;
    logic [31:0]            disc_cnt_q;
    logic [`RGI_CODE_W-1:0] paired_q;
    logic [31:0]            resp_cyc;
    logic                   disc_trip;
    logic                   chain_ok;
    logic                   code_match;
    logic                   pair_accept;
    logic                   out_a_q;
    logic                   out_b_q;
    logic                   read_q;
    logic                   ready_q;
    logic                   error_q;
    logic                   win_out_q;
    rgi_state_type          state_out_q;

    rgi_pulse_if pif ();

    // ================================================================
    // Reset release through two flops
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // ================================================================
    // Decision terms
    // Response per variant
    assign resp_cyc = i_standalone ? P_RESP_SA_CYC
        : P_RESP_CYC + 32'(i_chain_depth) * P_RESP_STEP_CYC;
    assign disc_trip   = disc_cnt_q >= P_DISC_CYC;
    // Upstream open (both low) stops us; brief mismatch is tolerated
    assign chain_ok    = !i_chain_en
        || ((i_chain_in_a || i_chain_in_b) && !disc_trip);
    assign code_match  = i_code == paired_q;
    assign pair_accept = i_repair_en && win_q && i_pair_req;

    // ================================================================
    // State machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_INIT: begin
                if (init_cnt_q == P_READY_CYC - 32'h1) begin
                    state_d = ST_STOP;
                end
            end
            ST_STOP: begin
                if (i_tag_present && chain_ok) begin
                    state_d = ST_READ;
                end
            end
            ST_READ: begin
                if (!i_tag_present) begin
                    state_d = ST_STOP;
                end else if (i_code_valid) begin
                    if (code_match || pair_accept) begin
                        state_d = ST_ARM;
                    end else begin
                        state_d = ST_ERROR;
                    end
                end
            end
            ST_ARM: begin
                if (!i_tag_present || !chain_ok) begin
                    state_d = ST_STOP;
                end else if (arm_cnt_q >= resp_cyc - 32'h1) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!i_tag_present || !chain_ok) begin
                    state_d = ST_STOP;
                end
            end
            ST_ERROR: state_d = ST_ERROR;
            default:  state_d = ST_ERROR;
        endcase
        if (i_selftest_fault) begin
            state_d = ST_ERROR;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_INIT;
        end else begin
            state_q <= state_d;
        end
    end

    // ================================================================
    // Timers
    // Init self-test time
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            init_cnt_q <= 32'h0;
        end else if (state_q == ST_INIT) begin
            init_cnt_q <= init_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            arm_cnt_q <= 32'h0;
        end else if (state_q == ST_ARM) begin
            arm_cnt_q <= arm_cnt_q + 32'h1;
        end else begin
            arm_cnt_q <= 32'h0;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            win_q     <= 1'b0;
            win_cnt_q <= 32'h0;
        end else if (state_q == ST_INIT && state_d == ST_STOP) begin
            win_q     <= 1'b1;
            win_cnt_q <= 32'h0;
        end else if (win_q) begin
            win_cnt_q <= win_cnt_q + 32'h1;
            if (win_cnt_q == P_PAIR_CYC - 32'h1) begin
                win_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            disc_cnt_q <= 32'h0;
        end else if (!i_chain_en || i_chain_in_a == i_chain_in_b) begin
            disc_cnt_q <= 32'h0;
        end else if (!disc_trip) begin
            disc_cnt_q <= disc_cnt_q + 32'h1;
        end
    end

    // ================================================================
    // Paired code; only the reader side key changes, tags are fixed
    // Store new key
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            paired_q <= `RGI_PAIRED_RST;
        end else if (state_q == ST_READ && i_tag_present && i_code_valid
                     && !code_match && pair_accept) begin
            paired_q <= i_code;
        end
    end

    // ================================================================
    // Test pulses only while ON
    assign pif.en = state_q == ST_RUN;

    rgi_pulse_gen #(
        .P_PERIOD_CYC (P_PERIOD_CYC),
        .P_PULSE_CYC  (P_PULSE_CYC)
    ) u_pulse (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .pif     (pif.gen)
    );

    // ================================================================
    // Registered outputs; both lanes share one state, so zero skew
    // Outputs follow RUN
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_a_q     <= 1'b0;
            out_b_q     <= 1'b0;
            read_q      <= 1'b0;
            ready_q     <= 1'b0;
            error_q     <= 1'b0;
            win_out_q   <= 1'b0;
            state_out_q <= ST_INIT;
        end else begin
            out_a_q     <= state_q == ST_RUN && !pif.pulse[0];
            out_b_q     <= state_q == ST_RUN && !pif.pulse[1];
            read_q      <= state_q == ST_READ;
            ready_q     <= state_q != ST_INIT && state_q != ST_ERROR;
            error_q     <= state_q == ST_ERROR;
            win_out_q   <= win_q && i_repair_en;
            state_out_q <= state_q;
        end
    end

    assign o_out_a       = out_a_q;
    assign o_out_b       = out_b_q;
    assign o_read_req    = read_q;
    assign o_ready       = ready_q;
    assign o_error       = error_q;
    assign o_pair_window = win_out_q;
    assign o_state       = state_out_q;

    // ================================================================
    // Checks
    property p_err_latch;
        @(posedge i_clk) disable iff (!rst_n)
        state_q == ST_ERROR |=> state_q == ST_ERROR ##1 !o_out_a && !o_out_b;
    endproperty
    a_err_latch: assert property (p_err_latch)
        else $error("error state left or outputs ON");

    property p_bad_code;
        @(posedge i_clk) disable iff (!rst_n)
        state_q == ST_READ && i_tag_present && i_code_valid && !code_match
            && !pair_accept |=> state_q == ST_ERROR;
    endproperty
    a_bad_code: assert property (p_bad_code)
        else $error("foreign code not rejected");

    property p_off_unless_run;
        @(posedge i_clk) disable iff (!rst_n)
        state_q != ST_RUN |=> !o_out_a && !o_out_b;
    endproperty
    a_off_unless_run: assert property (p_off_unless_run)
        else $error("output ON outside run");

    property p_tag_gone;
        @(posedge i_clk) disable iff (!rst_n)
        state_q == ST_RUN && !i_tag_present |-> ##2 !o_out_a && !o_out_b;
    endproperty
    a_tag_gone: assert property (p_tag_gone)
        else $error("outputs not OFF two cycles after tag left");

    property p_skew;
        @(posedge i_clk) disable iff (!rst_n)
        $fell(o_out_a) && $past(state_q) != ST_RUN |-> !o_out_b;
    endproperty
    a_skew: assert property (p_skew)
        else $error("lanes switched OFF apart");

    property p_on_delay;
        @(posedge i_clk) disable iff (!rst_n)
        state_q == ST_RUN && $past(state_q) == ST_ARM
            |-> $past(arm_cnt_q) == $past(resp_cyc) - 32'h1;
    endproperty
    a_on_delay: assert property (p_on_delay)
        else $error("run entered before response time");

    // Tag code is only meaningful in its valid cycle, so check at arming
    property p_rise_cause;
        @(posedge i_clk) disable iff (!rst_n)
        state_q == ST_ARM && $past(state_q) == ST_READ
            |-> $past(i_code_valid) && $past(code_match || pair_accept);
    endproperty
    a_rise_cause: assert property (p_rise_cause)
        else $error("armed without paired code");

    property p_disc;
        @(posedge i_clk) disable iff (!rst_n)
        i_chain_en && disc_trip && state_q == ST_RUN |=> state_q == ST_STOP;
    endproperty
    a_disc: assert property (p_disc)
        else $error("discrepancy timeout ignored");

    property p_ready_time;
        @(posedge i_clk) disable iff (!rst_n)
        state_q == ST_INIT |-> init_cnt_q < P_READY_CYC;
    endproperty
    a_ready_time: assert property (p_ready_time)
        else $error("init exceeded ready time");

    property p_pair_window;
        @(posedge i_clk) disable iff (!rst_n)
        paired_q != $past(paired_q) |-> $past(win_q) && $past(i_repair_en);
    endproperty
    a_pair_window: assert property (p_pair_window)
        else $error("key changed outside pairing window");
endmodule

// ### rgi_tag_model.sv
`timescale 1ns/1ps
// ====================================================================
// Coded tag on the far side of the radio field
module rgi_tag_model #(
    parameter logic [31:0] P_CODE    = 32'h5A5A_0001,
    // Arbitrary foreign code, any value but P_CODE
    parameter logic [31:0] P_FOREIGN = 32'hC3C3_7E11
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_in_field,
    input  wire logic        i_foreign,
    input  wire logic [7:0]  i_delay,
    input  wire logic        i_read_req,
    output logic             o_tag_present,
    output logic             o_code_valid,
    output logic [31:0]      o_code
);
    logic [7:0] wait_q;
    logic       done_q;

    assign o_tag_present = i_in_field;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wait_q       <= 8'h00;
            done_q       <= 1'b0;
            o_code_valid <= 1'b0;
            o_code       <= 32'h0000_0000;
        end else begin
            o_code_valid <= 1'b0;
            // Not held outside the valid cycle
            o_code       <= ~o_code;
            if (!i_read_req || !i_in_field) begin
                wait_q <= 8'h00;
                done_q <= 1'b0;
            end else if (!done_q) begin
                if (wait_q >= i_delay) begin
                    o_code_valid <= 1'b1;
                    o_code       <= i_foreign ? P_FOREIGN : P_CODE;
                    done_q       <= 1'b1;
                end
                wait_q <= wait_q + 8'h01;
            end
        end
    end
endmodule

// ### rfid_guard_interlock_output_control_test.sv
`timescale 1ns/1ps
module rfid_guard_interlock_output_control_test;
    import rgi_pkg::*;
    // Short counts keep the run brief
    localparam int READY = 20, PAIR = 50, RESP = 10, STEP = 3;
    localparam int SA = 15, DISC = 5, PULSE = 2, PERIOD = 20;
    logic          clk = 0, rst_b = 0, in_field = 0, foreign = 0;
    logic          fault = 0, sa = 0, chain_en = 0, ca = 1, cb = 1;
    logic          repair_en = 1, pair_req = 0;
    logic [7:0]    delay = 8'h00;
    logic [3:0]    depth = 4'h0;
    logic [31:0]   rng = 32'h0000_F4FD;
    logic [31:0]   code;
    logic          tag, code_valid, read_req, out_a, out_b;
    logic          ready, err, pwin;
    rgi_state_type state;
    int            fail_count = 0, n_tests = 0, k, i, ma, mb, la, lb;
    int            pa, pb;
    logic          both;

    always #5 clk = ~clk;

    rgi_tag_model u_tag (.i_clk(clk), .i_rst_b(rst_b), .i_in_field(in_field),
        .i_foreign(foreign), .i_delay(delay), .i_read_req(read_req),
        .o_tag_present(tag), .o_code_valid(code_valid), .o_code(code));

    rgi_interlock_ctrl #(.P_RESP_CYC(RESP), .P_RESP_STEP_CYC(STEP),
        .P_RESP_SA_CYC(SA), .P_READY_CYC(READY), .P_PAIR_CYC(PAIR),
        .P_DISC_CYC(DISC), .P_PULSE_CYC(PULSE), .P_PERIOD_CYC(PERIOD)
    ) u_dut (.i_clk(clk), .i_rst_b(rst_b), .i_tag_present(tag),
        .i_code_valid(code_valid), .i_code(code),
        .i_selftest_fault(fault), .i_standalone(sa), .i_chain_en(chain_en),
        .i_chain_depth(depth), .i_chain_in_a(ca), .i_chain_in_b(cb),
        .i_repair_en(repair_en), .i_pair_req(pair_req), .o_out_a(out_a),
        .o_out_b(out_b), .o_read_req(read_req), .o_ready(ready),
        .o_error(err), .o_pair_window(pwin), .o_state(state));

    // ================================================================
    // Helpers
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic int resp(input logic s, input logic [3:0] d);
        return s ? SA : RESP + int'(d) * STEP;
    endfunction

    task automatic step();
        @(negedge clk);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            $display("BAD %0t got %0h exp %0h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic check_state(input rgi_state_type got,
                               input rgi_state_type exp);
        n_tests++;
        if (got !== exp) begin
            $display("BAD %0t got %0h exp %0h", $time, got, exp);
            fail_count++;
        end
    endtask

    // Count must lie in lo..hi
    task automatic check_rng(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            $display("BAD %0t got %0h exp %0h..%0h", $time, got, lo, hi);
            fail_count++;
        end
    endtask

    task automatic wait_sig(input int w, input logic v, input int lim,
                            output int n);
        logic s;
        for (n = 0; n <= lim; n++) begin
            s = (w == 0) ? out_a : (w == 1) ? ready : (w == 2) ? pwin :
                (w == 3) ? code_valid : (w == 4) ? (out_a | out_b) : err;
            if (s === v) return;
            step();
        end
        $display("BAD %0t wait %0h got %0h exp %0h", $time, w, s, v);
        fail_count++;
        end_of_test();
    endtask

    task automatic do_reset();
        rst_b = 1'b0;
        repeat (20) step();
        rst_b = 1'b1;
        both = 1'b0;
        for (k = 0; k < READY + 10 && ready !== 1'b1; k++) begin
            if (out_a !== 1'b0 || out_b !== 1'b0) both = 1'b1;
            step();
        end
        check_bit(both, 1'b0);
        check_rng(k, READY - 1, READY + 4);
        check_bit(ready, 1'b1);
    endtask

    // Tag arrives, expect ON after the response count
    task automatic close(input int exp);
        in_field = 1'b1;
        wait_sig(3, 1'b1, 60, k);
        check_bit(read_req, 1'b1);
        step();
        wait_sig(0, 1'b1, exp + 10, k);
        check_rng(k + 1, exp + 1, exp + 3);
        check_bit(out_b, 1'b1);
    endtask

    task automatic open_guard();
        in_field = 1'b0;
        wait_sig(4, 1'b0, 6, k);
        check_rng(k, 0, 3);
        step();
        check_state(state, ST_STOP);
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    // ================================================================
    // Main sequence
    // Auto start only, no start command
    initial begin
        do_reset();
        done("power up");
        check_bit(pwin, 1'b1);
        wait_sig(2, 1'b0, PAIR + 6, k);
        check_rng(k, PAIR - 3, PAIR + 3);
        done("pairing window");
        for (i = 0; i < 5; i++) begin
            rng = xorshift(rng);
            sa = (i == 0);
            depth = (i == 2) ? 4'hF : (i > 2) ? rng[3:0] : 4'h0;
            delay = {5'h00, rng[6:4]};
            close(resp(sa, depth));
            {ma, mb, la, lb, pa, pb, both} = '0;
            for (k = 0; k < 3 * PERIOD; k++) begin
                step();
                la = out_a ? 0 : la + 1;
                lb = out_b ? 0 : lb + 1;
                ma = (la > ma) ? la : ma;
                mb = (lb > mb) ? lb : mb;
                pa += (la == 1);
                pb += (lb == 1);
                if (!out_a && !out_b) both = 1'b1;
            end
            check_rng(ma, 1, PULSE);
            check_rng(mb, 1, PULSE);
            check_rng(pa, 2, 4);
            check_rng(pb, 2, 4);
            check_bit(both, 1'b0);
            check_state(state, ST_RUN);
            open_guard();
            done("switch on and off");
        end
        chain_en = 1'b1;
        depth = 4'h1;
        close(resp(1'b0, 4'h1));
        ca = 1'b0;
        repeat (DISC - 2) step();
        ca = 1'b1;
        step();
        check_state(state, ST_RUN);
        cb = 1'b0;
        for (k = 0; k < DISC + 8 && state === ST_RUN; k++) step();
        check_rng(k, DISC - 1, DISC + 3);
        step();
        step();
        check_bit(out_a | out_b, 1'b0);
        cb = 1'b1;
        open_guard();
        chain_en = 1'b0;
        done("chain discrepancy");
        foreign = 1'b1;
        pair_req = 1'b1;
        in_field = 1'b1;
        wait_sig(5, 1'b1, 80, k);
        check_bit(out_a | out_b, 1'b0);
        foreign = 1'b0;
        in_field = 1'b0;
        repeat (4) step();
        in_field = 1'b1;
        repeat (40) step();
        check_bit(err, 1'b1);
        check_bit(out_a | out_b, 1'b0);
        check_state(state, ST_ERROR);
        in_field = 1'b0;
        done("foreign code");
        do_reset();
        check_bit(err, 1'b0);
        foreign = 1'b1;
        depth = 4'h0;
        close(RESP);
        check_bit(err, 1'b0);
        fault = 1'b1;
        wait_sig(4, 1'b0, 6, k);
        check_rng(k, 0, 3);
        wait_sig(5, 1'b1, 4, k);
        check_bit(out_a | out_b, 1'b0);
        done("pairing and fault");
        end_of_test();
    end
endmodule
